/* File: common/smc_pkg.sv */
/*
  Constants, field layouts and carrier types for the serial mode, clock
  counter and status block. Assumes a 200 MHz system clock and a classic
  Wishbone register bus with 32-bit data and byte addresses.
*/
// How it works
// [R1] Channel bit 0 selects channel zero, 1 channel one; other pins are ports.
// [R2] Protocol bit 0 selects clocked serial I/O, 1 selects the 2-wire bus.
// [R3] Software keeps the protocol bit 0 whenever channel one is selected.
// [R4] Clock source 0 means external clock or slave, 1 internal clock or master.
// [R5] The internal shift clock rate comes from the frequency register.
// [R6] On the 2-wire bus the transmit bit picks receive at 0, transmit at 1.
// [R7] Channel zero serial I/O: transmit bit makes data pin input or output.
// [R8] Channel one serial I/O: transmit bit 1 gives serial out, 0 a port.
// [R9] External clock with clock pin direction 1 makes that pin a plain output.
// [R10] Counter counts clock pin rises from 0, wrapping from 9 back to 1.
// [R11] Bus mode: counter clears on start and on change to serial I/O.
// [R12] Serial mode: counter clears on wait register write and change to bus.
// [R13] Counter clears on power-on reset and on clock stop.
// [R14] Mode register at 08H holds channel, protocol, source, transmit; resets 0.
// [R15] Status is read-only: count-eight, count-nine, start-seen, bus-busy.
// [R16] Bus-busy sets on start and clears on stop in bus mode.
// [R17] Bus-busy is held at 0 while serial I/O mode is selected.
// [R18] Start-seen sets on start and clears when the counter reads 9.
// [R19] Count-nine sets at count 9 and clears at count 0 or 1.
// [R20] Count-eight sets at count 8 and clears at count 0 or 1.
// [R21] Software reads the shift register only while count-eight is 1.
// [R22] A bus master reads acknowledge between two count-nine events.
// [R23] The bus supports one master; any arbitration is left to software.
// [R24] Start is data falling with clock high; stop is data rising with clock high.
package smc_pkg;

  // ----------------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ----------------------------------------------------------------------
  localparam int ADR_W = 10;
  localparam logic [7:0] IDX_MODE = 8'h08;
  localparam logic [7:0] IDX_STATUS = 8'h28;
  localparam logic [7:0] IDX_FREQ = 8'h39;
  localparam logic [7:0] IDX_PORT_DIR = 8'h30;
  localparam logic [7:0] IDX_PORT_LATCH = 8'h31;
  localparam logic [7:0] IDX_WAIT = 8'h32;

  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int BIT_CHANNEL = 3;
  localparam int BIT_PROTOCOL = 2;
  localparam int BIT_CLK_SRC = 1;
  localparam int BIT_TX = 0;
  localparam int PIN_SDA = 0;
  localparam int PIN_SCL = 1;
  localparam int PIN_SCK = 2;
  localparam int PIN_SO = 3;
  localparam int PIN_SI = 4;

  // ----------------------------------------------------------------------
  // Reset values and counter marks.
  // ----------------------------------------------------------------------
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [3:0] FREQ_RST = 4'h0;
  localparam logic [4:0] PORT_DIR_RST = 5'h00;
  localparam logic [4:0] PORT_LATCH_RST = 5'h00;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_RESTART = 4'h1;
  localparam logic [3:0] CNT_EIGHT = 4'h8;
  localparam logic [3:0] CNT_WRAP = 4'h9;

  // ----------------------------------------------------------------------
  // Timing: the internal shift clock half period is (freq + 1) base units.
  // ----------------------------------------------------------------------
  localparam int SYS_CLK_MHZ = 200;
  localparam int SHIFT_HALF_BASE_NS = 500;
  localparam int SHIFT_HALF_BASE_CYC = (SHIFT_HALF_BASE_NS * SYS_CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------------
  // Carrier types.
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic count_eight_flag;
    logic count_nine_flag;
    logic start_seen_flag;
    logic bus_busy_flag;
  } smc_status_t;

  typedef struct packed {
    logic si_out;
    logic si_oe;
    logic so_out;
    logic so_oe;
    logic sck_out;
    logic sck_oe;
    logic scl_out;
    logic scl_oe;
    logic sda_out;
    logic sda_oe;
  } smc_pins_out_t;

  typedef struct packed {
    logic si_in;
    logic so_in;
    logic sck_in;
    logic scl_in;
    logic sda_in;
  } smc_pins_in_t;

  function automatic logic [ADR_W-1:0] smc_reg_adr(input logic [7:0] idx);
    smc_reg_adr = {idx, 2'b00};
  endfunction : smc_reg_adr

endpackage : smc_pkg

/* File: logic/smc_serial_mode_counter_status.sv */
/*
  Mode register, shift clock counter, status flags and pin steering of the
  dual-channel serial interface. Assumes a classic Wishbone master on the
  system clock, pins that arrive asynchronously, and a shift register
  datapath outside that supplies the transmit bit and takes the edges.
*/
`timescale 1ns/100ps
module smc_serial_mode_counter_status #(
  parameter int HALF_BASE_CYC = smc_pkg::SHIFT_HALF_BASE_CYC
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Clock stop from the power controller
  input wire logic clock_stop_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [smc_pkg::ADR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Shift datapath
  input wire logic tx_bit_in,
  output logic rx_bit_out,
  output logic shift_edge_out,
  output logic [3:0] clock_count_out,
  output smc_pkg::smc_status_t status_out,
  // Pins
  input wire smc_pkg::smc_pins_in_t pins_in,
  output smc_pkg::smc_pins_out_t pins_out
);
  import smc_pkg::*;

  // The divider is 17 bits wide, so sixteen times the base must still fit.
  if (HALF_BASE_CYC < 1 || HALF_BASE_CYC > 4096) begin : g_bad_half
    $error("HALF_BASE_CYC out of range");
  end

  // ----------------------------------------------------------------------
  // Register bus.
  // ----------------------------------------------------------------------
  logic ack_q;
  logic [31:0] rdat_q;
  logic [3:0] mode_q;
  logic [3:0] freq_q;
  logic [4:0] dir_q;
  logic [4:0] latch_q;
  smc_status_t stat_q;
  logic req;
  logic wr;
  logic wait_wr;

  assign req = wb_cyc_in & wb_stb_in & ~ack_q;
  assign wr = req & wb_we_in & wb_sel_in[0];
  assign wait_wr = wr && wb_adr_in == smc_reg_adr(IDX_WAIT);

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // Unmapped addresses are answered with zero so the master never hangs.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdat_q <= 32'h0000_0000;
    end else if (req && !wb_we_in) begin
      if (wb_adr_in == smc_reg_adr(IDX_MODE)) begin
        rdat_q <= {28'h000_0000, mode_q};
      end else if (wb_adr_in == smc_reg_adr(IDX_STATUS)) begin
        rdat_q <= {28'h000_0000, stat_q}; // R15
      end else if (wb_adr_in == smc_reg_adr(IDX_FREQ)) begin
        rdat_q <= {28'h000_0000, freq_q};
      end else if (wb_adr_in == smc_reg_adr(IDX_PORT_DIR)) begin
        rdat_q <= {27'h000_0000, dir_q};
      end else if (wb_adr_in == smc_reg_adr(IDX_PORT_LATCH)) begin
        rdat_q <= {27'h000_0000, latch_q};
      end else begin
        rdat_q <= 32'h0000_0000;
      end
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdat_q;

  // The status register has no write path; writes to it are acknowledged only.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_q <= MODE_RST; // R14
    end else if (wr && wb_adr_in == smc_reg_adr(IDX_MODE)) begin
      mode_q <= wb_dat_in[3:0]; // R14
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      freq_q <= FREQ_RST;
      dir_q <= PORT_DIR_RST;
      latch_q <= PORT_LATCH_RST;
    end else if (wr) begin
      if (wb_adr_in == smc_reg_adr(IDX_FREQ)) begin
        freq_q <= wb_dat_in[3:0];
      end else if (wb_adr_in == smc_reg_adr(IDX_PORT_DIR)) begin
        dir_q <= wb_dat_in[4:0];
      end else if (wb_adr_in == smc_reg_adr(IDX_PORT_LATCH)) begin
        latch_q <= wb_dat_in[4:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Mode decode.
  // ----------------------------------------------------------------------
  logic ch1_sel;
  logic bus_mode;
  logic int_clk_sel;
  logic tx_sel;

  assign ch1_sel = mode_q[BIT_CHANNEL]; // R1
  // Channel one has no bus hardware, so a stray protocol bit is ignored there.
  assign bus_mode = mode_q[BIT_PROTOCOL] & ~ch1_sel; // R2 R3
  assign int_clk_sel = mode_q[BIT_CLK_SRC]; // R4
  assign tx_sel = mode_q[BIT_TX]; // R6

  // ----------------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------------
  smc_pins_in_t sync1_q;
  smc_pins_in_t sync2_q;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else begin
      sync1_q <= pins_in;
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------------
  // Internal shift clock generator.
  // ----------------------------------------------------------------------
  logic [16:0] div_q;
  logic int_clk_q;
  logic [16:0] half_cyc;

  assign half_cyc = 17'((32'(freq_q) + 32'd1) * 32'(HALF_BASE_CYC)); // R5

  // The generator idles high so that a newly selected master starts cleanly.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_q <= 17'h0_0000;
      int_clk_q <= 1'b1;
    end else if (!int_clk_sel || clock_stop_in) begin
      div_q <= 17'h0_0000;
      int_clk_q <= 1'b1;
    end else if (div_q >= half_cyc - 17'h0_0001) begin
      div_q <= 17'h0_0000;
      int_clk_q <= ~int_clk_q; // R5
    end else begin
      div_q <= div_q + 17'h0_0001;
    end
  end

  // ----------------------------------------------------------------------
  // Start and stop detection on channel zero.
  // ----------------------------------------------------------------------
  logic sda_prev_q;
  logic start_det;
  logic stop_det;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sda_prev_q <= 1'b1;
    end else begin
      sda_prev_q <= sync2_q.sda_in;
    end
  end

  assign start_det = bus_mode & sync2_q.scl_in & sda_prev_q & ~sync2_q.sda_in; // R24
  assign stop_det = bus_mode & sync2_q.scl_in & ~sda_prev_q & sync2_q.sda_in; // R24

  // ----------------------------------------------------------------------
  // Clock counter.
  // ----------------------------------------------------------------------
  logic clk_lvl;
  logic clk_prev_q;
  logic clk_rise;
  logic bus_prev_q;
  logic cnt_clr;
  logic [3:0] cnt_q;

  always_comb begin
    if (int_clk_sel) begin
      clk_lvl = int_clk_q;
    end else if (ch1_sel) begin
      clk_lvl = sync2_q.sck_in; // R10
    end else begin
      clk_lvl = sync2_q.scl_in; // R10
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_prev_q <= 1'b1;
      bus_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= clk_lvl;
      bus_prev_q <= bus_mode;
    end
  end

  assign clk_rise = clk_lvl & ~clk_prev_q;
  assign cnt_clr = clock_stop_in // R13
    | (bus_prev_q != bus_mode) // R11 R12
    | start_det // R11
    | (wait_wr & ~bus_mode); // R12

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= CNT_ZERO; // R13
    end else if (cnt_clr) begin
      cnt_q <= CNT_ZERO;
    end else if (clk_rise) begin
      cnt_q <= (cnt_q == CNT_WRAP) ? CNT_RESTART : cnt_q + 4'h1; // R10
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_edge_out <= 1'b0;
      rx_bit_out <= 1'b0;
    end else begin
      shift_edge_out <= clk_rise & ~cnt_clr;
      rx_bit_out <= ch1_sel ? sync2_q.si_in : sync2_q.sda_in;
    end
  end

  assign clock_count_out = cnt_q;

  // ----------------------------------------------------------------------
  // Status flags.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stat_q <= '0;
    end else begin
      if (cnt_q == CNT_EIGHT) begin
        stat_q.count_eight_flag <= 1'b1; // R20
      end else if (cnt_q <= CNT_RESTART) begin
        stat_q.count_eight_flag <= 1'b0; // R20
      end
      if (cnt_q == CNT_WRAP) begin
        stat_q.count_nine_flag <= 1'b1; // R19
      end else if (cnt_q <= CNT_RESTART) begin
        stat_q.count_nine_flag <= 1'b0; // R19
      end
      // A start always beats the clear that count nine would make.
      if (start_det) begin
        stat_q.start_seen_flag <= 1'b1; // R18
      end else if (cnt_q == CNT_WRAP) begin
        stat_q.start_seen_flag <= 1'b0; // R18
      end
      if (!bus_mode) begin
        stat_q.bus_busy_flag <= 1'b0; // R17
      end else if (start_det) begin
        stat_q.bus_busy_flag <= 1'b1; // R16
      end else if (stop_det) begin
        stat_q.bus_busy_flag <= 1'b0; // R16
      end
    end
  end

  assign status_out = stat_q;

  // ----------------------------------------------------------------------
  // Pin steering.
  // ----------------------------------------------------------------------
  // In bus mode the transmit and internal clock drives are open drain: they only ever pull low.
  always_comb begin
    pins_out.sda_out = latch_q[PIN_SDA];
    pins_out.sda_oe = dir_q[PIN_SDA];
    pins_out.scl_out = latch_q[PIN_SCL];
    pins_out.scl_oe = dir_q[PIN_SCL];
    pins_out.sck_out = latch_q[PIN_SCK];
    pins_out.sck_oe = dir_q[PIN_SCK];
    pins_out.so_out = latch_q[PIN_SO];
    pins_out.so_oe = dir_q[PIN_SO];
    pins_out.si_out = latch_q[PIN_SI];
    pins_out.si_oe = dir_q[PIN_SI];
    if (!ch1_sel) begin
      if (tx_sel) begin
        pins_out.sda_out = bus_mode ? 1'b0 : tx_bit_in; // R7 R6
        pins_out.sda_oe = bus_mode ? ~tx_bit_in : 1'b1; // R7 R6
      end
      if (int_clk_sel) begin
        pins_out.scl_out = bus_mode ? 1'b0 : int_clk_q; // R4
        pins_out.scl_oe = bus_mode ? ~int_clk_q : 1'b1; // R4 R23
      end
    end else begin
      if (int_clk_sel) begin
        pins_out.sck_out = int_clk_q; // R4
        pins_out.sck_oe = 1'b1;
      end
      if (tx_sel) begin
        pins_out.so_out = tx_bit_in; // R8
        pins_out.so_oe = 1'b1; // R8
      end
    end
    // R9: with an external clock the direction bit alone decides, as above.
  end

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  sequence s_clean_rise;
    clk_rise && !cnt_clr;
  endsequence

  sequence s_bus_start;
    start_det ##1 1'b1;
  endsequence

  a_count_wrap: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R10
    s_clean_rise and cnt_q == CNT_WRAP |=> cnt_q == CNT_RESTART)
    else $error("counter did not wrap from nine to one");

  a_count_step: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R10
    s_clean_rise and cnt_q < CNT_WRAP |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("counter did not step on a clock rise");

  a_start_effects: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R11
    s_bus_start |-> cnt_q == CNT_ZERO && stat_q.start_seen_flag && stat_q.bus_busy_flag)
    else $error("start did not clear counter and set flags");

  a_stop_counter: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R13
    clock_stop_in |=> cnt_q == CNT_ZERO)
    else $error("clock stop did not clear counter");

  a_serial_busy: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R17
    !bus_mode |=> !stat_q.bus_busy_flag)
    else $error("busy flag set in serial mode");

  a_stop_busy: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R16
    stop_det && !start_det |=> !stat_q.bus_busy_flag)
    else $error("stop did not clear busy flag");

  a_eight_flag: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R20
    cnt_q <= CNT_RESTART |=> !stat_q.count_eight_flag)
    else $error("count eight flag did not clear at count one");

  a_nine_flag: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R19
    cnt_q == CNT_WRAP |=> stat_q.count_nine_flag && (!stat_q.start_seen_flag || $past(start_det)))
    else $error("count nine did not set its flag");

  a_mode_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R14
    wr && wb_adr_in == smc_reg_adr(IDX_MODE) |=> mode_q == $past(wb_dat_in[3:0]))
    else $error("mode register write lost");

  a_wait_clear: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R12
    wait_wr && !bus_mode |=> cnt_q == CNT_ZERO)
    else $error("wait write did not clear counter in serial mode");

  a_soft_clock: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R9
    !int_clk_sel && !ch1_sel |-> pins_out.scl_oe == dir_q[PIN_SCL])
    else $error("clock pin direction not followed");

  a_ch1_so: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R8
    ch1_sel && tx_sel |-> pins_out.so_oe && pins_out.so_out == tx_bit_in)
    else $error("serial out pin not driven");

endmodule : smc_serial_mode_counter_status

/* File: verification/smc_link_partner.sv */
/*
  Behavioural far side of the serial link: one bus master or serial
  peripheral that drives the clock and data pins. Assumes the design
  drives its pins through output enables and that bus lines have pull-ups.
*/
`timescale 1ns/100ps
module smc_link_partner (
  // Pin outputs of the design
  input wire smc_pkg::smc_pins_out_t pins_out_in,
  // Resolved pin levels back to the design
  output smc_pkg::smc_pins_in_t pins_in_out
);
  import smc_pkg::*;
  // Half of the 125 ns link clock period.
  localparam real HALF_NS = 62.5;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic sck_q = 1'b1;
  logic si_q = 1'b0;
  logic so_last_q = 1'b0;
  // --------------------------------------------------------------------
  // Pin resolution
  // --------------------------------------------------------------------
  // A released output line with no pull-up shows the inverse of its last
  // driven level, so a stale value can never pass for a live one.
  always @(pins_out_in) begin
    if (pins_out_in.so_oe) begin
      so_last_q = pins_out_in.so_out;
    end
  end
  always_comb begin
    pins_in_out.scl_in = (pins_out_in.scl_oe ? pins_out_in.scl_out : 1'b1) & scl_q;
    pins_in_out.sda_in = (pins_out_in.sda_oe ? pins_out_in.sda_out : 1'b1) & sda_q;
    pins_in_out.sck_in = pins_out_in.sck_oe ? pins_out_in.sck_out : sck_q;
    pins_in_out.so_in = pins_out_in.so_oe ? pins_out_in.so_out : ~so_last_q;
    pins_in_out.si_in = pins_out_in.si_oe ? pins_out_in.si_out : si_q;
  end
  // --------------------------------------------------------------------
  // Link traffic
  // --------------------------------------------------------------------
  // The clock stands high between frames and data moves only while the
  // clock is low, except in start and stop; this side never contends for the bus clock.
  task automatic clk_pulses(input int n, input bit ch1);
    repeat (n) begin
      if (ch1) begin
        sck_q = 1'b0;
        si_q = 1'($urandom());
      end else begin
        scl_q = 1'b0;
      end
      #HALF_NS;
      sck_q = 1'b1;
      scl_q = 1'b1;
      #HALF_NS;
    end
  endtask : clk_pulses
  task automatic start_cond();
    sda_q = 1'b1;
    #HALF_NS;
    sda_q = 1'b0;
    #HALF_NS;
  endtask : start_cond
  task automatic stop_cond();
    sda_q = 1'b0;
    #HALF_NS;
    sda_q = 1'b1;
    #HALF_NS;
  endtask : stop_cond
endmodule : smc_link_partner

/* File: verification/smc_serial_mode_counter_status_tb_top.sv */
/*
  Self-checking bench for the serial mode, counter and status block.
  Assumes the link partner model on the pins and a Wishbone master here.
*/
`timescale 1ns/100ps
module smc_serial_mode_counter_status_tb_top;
  import smc_pkg::*;
  localparam int HB = 2;
  localparam logic [31:0] FULL = 32'hFFFF_FFFF;
  typedef struct packed {logic [31:0] exp; logic [31:0] mask;} smc_note_t;
  logic clk_sys_in, rst_n_in, clock_stop_in, wb_cyc, wb_stb, wb_we, wb_ack;
  logic tx_bit, rx_bit, shift_edge, cnt_chk, b;
  logic [ADR_W-1:0] wb_adr;
  logic [31:0] wb_dat_w, wb_dat_r;
  logic [3:0] count, v;
  smc_status_t status;
  smc_pins_in_t pins_in;
  smc_pins_out_t pins_out;
  smc_note_t rd_q[$];
  logic [3:0] cnt_q[$];
  int n_fail, cmp_count, c, f, t;

  smc_serial_mode_counter_status #(.HALF_BASE_CYC(HB)) DUT (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .clock_stop_in(clock_stop_in),
    .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
    .wb_sel_in(4'hF), .wb_dat_in(wb_dat_w), .wb_dat_out(wb_dat_r), .wb_ack_out(wb_ack),
    .tx_bit_in(tx_bit), .rx_bit_out(rx_bit), .shift_edge_out(shift_edge),
    .clock_count_out(count), .status_out(status), .pins_in(pins_in), .pins_out(pins_out));
  smc_link_partner u_link (.pins_out_in(pins_out), .pins_in_out(pins_in));

  // --------------------------------------------------------------------
  // Reporting and comparison
  // --------------------------------------------------------------------
  task automatic fail(input string msg);
    n_fail++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask : fail
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  task automatic cmp_word(input logic [31:0] got, input smc_note_t n);
    cmp_count++;
    if ((got & n.mask) !== (n.exp & n.mask)) fail($sformatf("word %h exp %h", got, n.exp));
  endtask : cmp_word
  task automatic cmp_cnt(input logic [3:0] got, input logic [3:0] exp);
    cmp_count++;
    if (got !== exp) fail($sformatf("count %h exp %h", got, exp));
  endtask : cmp_cnt
  task automatic cmp_pin(input logic got, input logic exp, input string nm);
    cmp_count++;
    if (got !== exp) fail($sformatf("pin %s is %b", nm, got));
  endtask : cmp_pin
  function automatic logic [31:0] st(input int k, input logic s, input logic y);
    st = {28'h0, (k == 8 || k == 9), (k == 9), s, y};
  endfunction : st

  // --------------------------------------------------------------------
  // Drivers
  // --------------------------------------------------------------------
  task automatic wb_xfer(input logic we, input logic [7:0] idx, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys_in);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'b00};
    wb_dat_w <= d;
    do begin
      @(posedge clk_sys_in);
      k++;
    end while (wb_ack !== 1'b1 && k < 50);
    if (k >= 50) begin
      fail("ack timeout");
      final_report();
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : wb_xfer
  task automatic wb_rd(input logic [7:0] idx, input logic [31:0] e, input logic [31:0] m);
    rd_q.push_back('{e, m});
    wb_xfer(1'b0, idx, 32'h0);
  endtask : wb_rd
  task automatic pulses(input int n, input bit ch1);
    repeat (n) begin
      c = (c == 9) ? 1 : c + 1;
      cnt_q.push_back(c[3:0]);
    end
    u_link.clk_pulses(n, ch1);
    repeat (8) @(posedge clk_sys_in);
    if (cnt_q.size() != 0) fail("missing shift edges");
  endtask : pulses
  task automatic edge_gap(output int n);
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (shift_edge !== 1'b1 && n < 1000);
    if (n >= 1000) begin
      fail("no shift edge");
      final_report();
    end
  endtask : edge_gap
  task automatic settle_cnt(input logic [3:0] e);
    repeat (3) @(posedge clk_sys_in);
    cmp_cnt(count, e);
  endtask : settle_cnt

  // --------------------------------------------------------------------
  // Result watcher: takes the oldest note as each result appears
  // --------------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (wb_ack === 1'b1 && wb_we === 1'b0) begin
      if (rd_q.size() == 0) fail("unexpected read");
      else cmp_word(wb_dat_r, rd_q.pop_front());
    end
    if (cnt_chk === 1'b1 && shift_edge === 1'b1) begin
      if (cnt_q.size() == 0) fail("unexpected shift edge");
      else cmp_cnt(count, cnt_q.pop_front());
    end
  end
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    repeat (100000) @(posedge clk_sys_in);
    fail("global timeout");
    final_report();
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    rst_n_in = 1'b0;
    clock_stop_in = 1'b0;
    {wb_cyc, wb_stb, wb_we, tx_bit, cnt_chk} = 5'h00;
    wb_adr = '0;
    wb_dat_w = 32'h0;
    n_fail = 0;
    cmp_count = 0;
    c = $urandom(48787);
    repeat (6) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    wb_rd(IDX_MODE, 32'h0, FULL);
    wb_rd(IDX_STATUS, 32'h0, FULL);
    wb_rd(8'h10, 32'h0, FULL);
    wb_xfer(1'b1, IDX_STATUS, 32'hF);
    wb_rd(IDX_STATUS, 32'h0, FULL);
    repeat (4) begin
      v = 4'($urandom());
      if (v[3]) v[2] = 1'b0;
      tx_bit <= 1'($urandom());
      wb_xfer(1'b1, IDX_MODE, {28'h0, v});
      wb_rd(IDX_MODE, {28'h0, v}, FULL);
    end
    $display("test registers done");
    wb_xfer(1'b1, IDX_MODE, 32'h0);
    wb_xfer(1'b1, IDX_WAIT, 32'h0);
    c = 0;
    cnt_chk = 1'b1;
    pulses($urandom_range(19, 10), 1'b0);
    wb_rd(IDX_STATUS, st(c, 1'b0, 1'b0), 32'hD);
    clock_stop_in <= 1'b1;
    @(posedge clk_sys_in);
    clock_stop_in <= 1'b0;
    settle_cnt(4'h0);
    c = 0;
    pulses(3, 1'b0);
    wb_xfer(1'b1, IDX_WAIT, 32'h0);
    settle_cnt(4'h0);
    c = 0;
    wb_xfer(1'b1, IDX_MODE, 32'h8);
    pulses(4, 1'b1);
    u_link.clk_pulses(2, 1'b0);
    $display("test serial counting done");
    wb_xfer(1'b1, IDX_MODE, 32'h0);
    pulses(5, 1'b0);
    wb_xfer(1'b1, IDX_MODE, 32'h4);
    settle_cnt(4'h0);
    cmp_pin(pins_out.sda_oe, 1'b0, "sda_oe");
    u_link.start_cond();
    c = 0;
    wb_rd(IDX_STATUS, st(0, 1'b1, 1'b1), FULL);
    pulses(9, 1'b0);
    wb_rd(IDX_STATUS, st(9, 1'b0, 1'b1), FULL);
    u_link.stop_cond();
    wb_rd(IDX_STATUS, st(9, 1'b0, 1'b0), FULL);
    pulses(2, 1'b0);
    wb_rd(IDX_STATUS, st(2, 1'b0, 1'b0), FULL);
    cmp_word(32'(status), '{32'h0, FULL});
    u_link.start_cond();
    settle_cnt(4'h0);
    c = 0;
    pulses(3, 1'b0);
    wb_xfer(1'b1, IDX_MODE, 32'h0);
    settle_cnt(4'h0);
    wb_rd(IDX_STATUS, 32'h0, 32'hD);
    u_link.start_cond();
    wb_rd(IDX_STATUS, 32'h0, 32'h1);
    u_link.stop_cond();
    $display("test bus flags done");
    cnt_chk = 1'b0;
    cmp_pin(pins_out.scl_oe, 1'b0, "scl_oe");
    wb_xfer(1'b1, IDX_MODE, 32'h1);
    cmp_pin(pins_out.sda_oe, 1'b1, "sda_oe");
    b = 1'($urandom());
    wb_xfer(1'b1, IDX_PORT_LATCH, (32'(b) << PIN_SCL) | (32'(b) << PIN_SDA));
    wb_xfer(1'b1, IDX_PORT_DIR, 32'h1 << PIN_SCL);
    cmp_pin(pins_out.scl_oe, 1'b1, "scl_oe");
    cmp_pin(pins_out.scl_out, b, "scl_out");
    wb_xfer(1'b1, IDX_PORT_DIR, 32'h1 << PIN_SDA);
    wb_xfer(1'b1, IDX_MODE, 32'h8);
    cmp_pin(pins_out.so_oe, 1'b0, "so_oe");
    cmp_pin(pins_out.sda_oe, 1'b1, "sda_oe");
    cmp_pin(pins_out.sda_out, b, "sda_out");
    wb_xfer(1'b1, IDX_MODE, 32'h9);
    cmp_pin(pins_out.so_oe, 1'b1, "so_oe");
    cmp_pin(rx_bit, u_link.si_q, "rx_bit");
    f = $urandom_range(3, 1);
    wb_xfer(1'b1, IDX_FREQ, f);
    wb_rd(IDX_FREQ, f, FULL);
    wb_xfer(1'b1, IDX_MODE, 32'hA);
    cmp_pin(pins_out.sck_oe, 1'b1, "sck_oe");
    edge_gap(t);
    edge_gap(t);
    edge_gap(t);
    cmp_word(t, '{2 * (f + 1) * HB, FULL});
    $display("test pins and clock done");
    repeat (4) @(posedge clk_sys_in);
    if (rd_q.size() != 0) fail("reads left unanswered");
    final_report();
  end
endmodule : smc_serial_mode_counter_status_tb_top
